// *** rtl/clc_pkg.sv ***
// Purpose: Constants for the channel limit and calibration register set
// Assumes: Q16.16 fixed point inside, temperatures in Q12.4 degrees C
// Notes:   Command codes are the register addresses on the command port
package clc_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
    localparam logic [7:0] CMD_SENSE_GAIN  = 8'h38;
    localparam logic [7:0] CMD_OC_FAULT    = 8'h46;
    localparam logic [7:0] CMD_OC_WARN     = 8'h4A;
    localparam logic [7:0] CMD_REV_FAULT   = 8'h4B;
    localparam logic [7:0] CMD_HOT_FAULT   = 8'h4F;
    localparam logic [7:0] CMD_HOT_WARN    = 8'h51;
    localparam logic [7:0] CMD_COLD_WARN   = 8'h52;
    localparam logic [7:0] CMD_COLD_FAULT  = 8'h53;
    localparam logic [7:0] CMD_HEAT_RISE   = 8'hB8;
    localparam logic [7:0] CMD_HEAT_TAU    = 8'hB9;
    localparam logic [7:0] CMD_HEAT_THETA  = 8'hBA;
    localparam logic [7:0] CMD_DAC_CODE    = 8'hE0;
    localparam logic [7:0] CMD_DISCH_COEF  = 8'hE9;
    localparam logic [7:0] CMD_GAIN_TC     = 8'hF6;
    localparam logic [7:0] CMD_DIODE_INV   = 8'hF8;
    localparam logic [7:0] CMD_TEMP_OFS    = 8'hF9;

    // ----------------------------------------------------------------
    // Stored word indices and reset values
    // ----------------------------------------------------------------
    localparam int NREG       = 14;
    localparam int IDX_GAIN   = 0;
    localparam int IDX_OCF    = 1;
    localparam int IDX_REVF   = 3;
    localparam int IDX_TC     = 10;
    localparam int IDX_DCOEF  = 13;
    localparam logic [15:0] RST_VAL [NREG] = '{
        16'hBA00, 16'hD280, 16'hCA80, 16'hB400, 16'hEA08, 16'hE3C0,
        16'h8000, 16'hCD80, 16'h8000, 16'h8000, 16'h0000, 16'h4000,
        16'h8000, 16'hC200};
    localparam logic [7:0]  VOUT_FORMAT = 8'h13;
    localparam logic [15:0] DAC_RST     = 16'h0000;
    localparam int          DAC_W       = 10;

    // ----------------------------------------------------------------
    // Fixed point (Q16.16) limits
    // ----------------------------------------------------------------
    localparam logic signed [31:0] FX_ONE   = 32'sh0001_0000;
    localparam logic signed [31:0] FX_MAX   = 32'sh7FFF_FFFF;
    localparam logic signed [31:0] FX_MIN   = -32'sh7FFF_FFFF;
    localparam logic signed [31:0] GAIN_MIN = 32'sh0000_028F;
    localparam logic signed [31:0] GAIN_MAX = 32'sh03E8_0000;
    localparam logic signed [31:0] CORR_MIN = 32'sh0000_4000;
    localparam logic signed [31:0] CORR_MAX = 32'sh0004_0000;
    localparam logic signed [31:0] REV_MAX  = -32'sh0000_0001;
    // 25.0 C in Q12.4; 2^20 * 4096 / 1e6 rounds to the scale below
    localparam logic signed [17:0] T_REF    = 18'sh0_0190;
    localparam logic signed [15:0] PPM_K    = 16'sh10C7;

endpackage : clc_pkg

// *** rtl/clc_regs.sv ***
// Purpose: Per-channel limit, calibration and DAC command register set
// Assumes: Command port is already decoded from the host link
// Notes:   Derived values are refreshed one channel per clock in turn
`timescale 1ns/100ps

// Contract
// [RQ1] Format byte reads type 000, exponent -13
// [RQ2] Undischarged turn-on sets flag, pulls alert low
// [RQ3] Failed channel held off until below threshold
// [RQ4] Coefficient above one disables the check
// [RQ5] DAC write needs on, rise done, mode 1x
// [RQ6] Mode 10 hard connects the stored code
// [RQ7] Mode 11 starts a soft connect
// [RQ8] After soft connect, code reads attach value
// [RQ9] DAC writes dropped in modes 00, 01
// [RQ10] DAC word: ten code bits, upper zero
// [RQ11] Gain clamped 0.01 to 1000, raw readback
// [RQ12] Current and trip levels use gain, correction
// [RQ13] Thermal correction clamped 0.25 to 4.0
// [RQ14] Invalid external temperature uses die temperature
// [RQ15] Overcurrent limit clamped nonnegative, raw readback
// [RQ16] Reverse limit clamped negative, raw readback
// [RQ17] Tempco is signed ppm per degree
// [RQ18] Gain word at 0x38, reset 0xBA00
// [RQ19] Overcurrent fault 0x46, warning 0x4A
// [RQ20] Reverse fault at 0x4B, reset 0xB400
// [RQ21] Temperature limits at 0x4F to 0x53
// [RQ22] Ideality inverse at 0xF8, reset 0x4000
// [RQ23] Discharge coefficient at 0xE9, reset 0xC200
// [RQ24] DAC word at 0xE0, resets to zero
module clc_regs #(
    parameter int NUM_CH = 4,
    parameter int PW     = 2
) (
    // Clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            resetn,
    // Command port
    input  wire logic                            cmd_valid,
    input  wire logic                            cmd_write,
    input  wire logic [PW-1:0]                   cmd_page,
    input  wire logic [7:0]                      cmd_code,
    input  wire logic [15:0]                     cmd_wdata,
    output logic                                 rsp_valid_q,
    output logic                                 rsp_ack_q,
    output logic [15:0]                          rsp_data_q,
    // Channel sequencing
    input  wire logic [NUM_CH-1:0]               on_cmd,
    input  wire logic [NUM_CH-1:0]               rise_done,
    input  wire logic [NUM_CH-1:0][15:0]         vout_target,
    input  wire logic [NUM_CH-1:0][15:0]         vout_meas,
    input  wire logic                            clear_faults,
    output logic      [NUM_CH-1:0]               chan_on_q,
    output logic      [NUM_CH-1:0]               discharge_flag_q,
    output logic                                 alert_low_pin_o_q,
    output logic                                 alert_low_pin_oe_n_q,
    // DAC connection
    input  wire logic [NUM_CH-1:0][1:0]          cfg_dac_mode,
    input  wire logic [NUM_CH-1:0]               soft_done,
    input  wire logic [NUM_CH-1:0][9:0]          soft_code,
    output logic      [NUM_CH-1:0][9:0]          dac_code_q,
    output logic      [NUM_CH-1:0]               dac_hard_q,
    output logic      [NUM_CH-1:0]               dac_soft_q,
    // Measurements
    input  wire logic [NUM_CH-1:0][31:0]         sense_mv,
    input  wire logic [NUM_CH-1:0][15:0]         ext_temp,
    input  wire logic [NUM_CH-1:0]               ext_valid,
    input  wire logic [NUM_CH-1:0][15:0]         self_heat,
    input  wire logic [15:0]                     die_temp,
    output logic      [NUM_CH-1:0][31:0]         iout_q,
    output logic      [NUM_CH-1:0][31:0]         oc_trip_q,
    output logic      [NUM_CH-1:0][31:0]         rev_trip_q
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic signed [31:0] sat32(
        input logic signed [63:0] v);
        if (v > 64'(clc_pkg::FX_MAX))
            return clc_pkg::FX_MAX;
        if (v < 64'(clc_pkg::FX_MIN))
            return clc_pkg::FX_MIN;
        return v[31:0];
    endfunction : sat32

    // Mantissa times 2^exponent, shifted into Q16.16
    function automatic logic signed [31:0] l11_fx(input logic [15:0] w);
        logic signed [63:0] v;
        logic        [5:0]  sh;
        v  = 64'(signed'(w[10:0]));
        sh = {w[15], w[15:11]} + 6'h10;
        return sat32(v <<< sh);
    endfunction : l11_fx

    function automatic logic signed [31:0] fx_mul(
        input logic signed [31:0] a,
        input logic signed [31:0] b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return sat32(p >>> 16);
    endfunction : fx_mul

    function automatic int reg_index(input logic [7:0] c);
        if (c == clc_pkg::CMD_SENSE_GAIN) return 0;
        else if (c == clc_pkg::CMD_OC_FAULT) return 1;
        else if (c == clc_pkg::CMD_OC_WARN) return 2;
        else if (c == clc_pkg::CMD_REV_FAULT) return 3;
        else if (c == clc_pkg::CMD_HOT_FAULT) return 4;
        else if (c == clc_pkg::CMD_HOT_WARN) return 5;
        else if (c == clc_pkg::CMD_COLD_WARN) return 6;
        else if (c == clc_pkg::CMD_COLD_FAULT) return 7;
        else if (c == clc_pkg::CMD_HEAT_TAU) return 8;
        else if (c == clc_pkg::CMD_HEAT_THETA) return 9;
        else if (c == clc_pkg::CMD_GAIN_TC) return 10;
        else if (c == clc_pkg::CMD_DIODE_INV) return 11;
        else if (c == clc_pkg::CMD_TEMP_OFS) return 12;
        else if (c == clc_pkg::CMD_DISCH_COEF) return 13;
        else return -1;
    endfunction : reg_index

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic [15:0] regs_q [NUM_CH][clc_pkg::NREG];
    logic [NUM_CH-1:0][9:0] dac_reg_q;
    logic [NUM_CH-1:0][1:0] mode_prev_q;

    int          idx;
    logic        page_ok;
    logic        is_fmt;
    logic        is_dac;
    logic        is_heat;
    logic        is_stored;
    logic        dac_wr_ok;
    logic        wr_stored;
    logic        wr_dac;
    logic        ack_d;
    logic [15:0] rdata_d;

    assign idx       = reg_index(cmd_code);
    assign page_ok   = 32'(cmd_page) < NUM_CH;
    assign is_fmt    = cmd_code == clc_pkg::CMD_VOUT_FORMAT;
    assign is_dac    = cmd_code == clc_pkg::CMD_DAC_CODE;
    assign is_heat   = cmd_code == clc_pkg::CMD_HEAT_RISE;
    assign is_stored = idx >= 0;
    // Write taken only with channel on, rise over, mode 1x [RQ5] [RQ9]
    assign dac_wr_ok = chan_on_q[cmd_page] && rise_done[cmd_page]
                       && cfg_dac_mode[cmd_page][1];
    assign wr_stored = cmd_valid && cmd_write && page_ok && is_stored;
    assign wr_dac    = cmd_valid && cmd_write && page_ok && is_dac
                       && dac_wr_ok;
    assign ack_d     = page_ok && (cmd_write
                       ? (is_stored || (is_dac && dac_wr_ok))
                       : (is_stored || is_dac || is_fmt || is_heat));

    always_comb begin
        rdata_d = 16'h0000;
        if (!page_ok || cmd_write) begin
            rdata_d = 16'h0000;
        end else if (is_fmt) begin
            rdata_d = {8'h00, clc_pkg::VOUT_FORMAT}; // [RQ1]
        end else if (is_dac) begin
            rdata_d = {6'h00, dac_reg_q[cmd_page]}; // [RQ10]
        end else if (is_heat) begin
            rdata_d = self_heat[cmd_page];
        end else if (is_stored) begin
            // Raw word, never the clamped value [RQ11] [RQ15] [RQ16]
            rdata_d = regs_q[cmd_page][idx];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rsp_valid_q <= 1'b0;
            rsp_ack_q   <= 1'b0;
            rsp_data_q  <= 16'h0000;
        end else begin
            rsp_valid_q <= cmd_valid;
            rsp_ack_q   <= cmd_valid && ack_d;
            rsp_data_q  <= cmd_valid ? rdata_d : 16'h0000;
        end
    end

    // Reset image of every page [RQ18] [RQ19] [RQ20] [RQ21] [RQ22] [RQ23]
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int r = 0; r < clc_pkg::NREG; r++) begin
                    regs_q[c][r] <= clc_pkg::RST_VAL[r];
                end
            end
        end else if (wr_stored) begin
            regs_q[cmd_page][idx] <= cmd_wdata;
        end
    end

    // ----------------------------------------------------------------
    // DAC connection
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                dac_reg_q[c] <= clc_pkg::DAC_RST[9:0]; // [RQ24]
            end
            mode_prev_q <= '0;
            dac_code_q  <= '0;
            dac_hard_q  <= '0;
            dac_soft_q  <= '0;
        end else begin
            mode_prev_q <= cfg_dac_mode;
            for (int c = 0; c < NUM_CH; c++) begin
                dac_hard_q[c] <= cfg_dac_mode[c] == 2'b10
                                 && mode_prev_q[c] != 2'b10; // [RQ6]
                dac_soft_q[c] <= cfg_dac_mode[c] == 2'b11
                                 && mode_prev_q[c] != 2'b11; // [RQ7]
                // Attach code replaces the stored one [RQ8]
                if (soft_done[c] && cfg_dac_mode[c] == 2'b11) begin
                    dac_reg_q[c] <= soft_code[c];
                end else if (wr_dac && 32'(cmd_page) == c) begin
                    dac_reg_q[c] <= cmd_wdata[9:0]; // [RQ10]
                end
                dac_code_q[c] <= dac_reg_q[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // Calibration arithmetic, one channel per cycle
    // ----------------------------------------------------------------
    logic [PW-1:0] rr_q;
    logic signed [31:0] gain_raw;
    logic signed [31:0] gain_eff;
    logic signed [31:0] oc_raw;
    logic signed [31:0] oc_eff;
    logic signed [31:0] rev_raw;
    logic signed [31:0] rev_eff;
    logic signed [31:0] coef_fx;
    logic signed [15:0] t_use;
    logic signed [17:0] dtemp;
    logic signed [63:0] ppm_prod;
    logic signed [31:0] corr_raw;
    logic signed [31:0] corr;
    logic signed [31:0] gc;
    logic signed [31:0] thr;
    logic signed [63:0] i_quot;
    logic [NUM_CH-1:0][31:0] thr_q;
    logic [NUM_CH-1:0]       chk_en_q;

    assign gain_raw = l11_fx(regs_q[rr_q][clc_pkg::IDX_GAIN]);
    assign gain_eff = gain_raw < clc_pkg::GAIN_MIN ? clc_pkg::GAIN_MIN
                    : gain_raw > clc_pkg::GAIN_MAX ? clc_pkg::GAIN_MAX
                    : gain_raw; // [RQ11]
    assign oc_raw   = l11_fx(regs_q[rr_q][clc_pkg::IDX_OCF]);
    assign oc_eff   = oc_raw < 0 ? 32'sh0000_0000 : oc_raw; // [RQ15]
    assign rev_raw  = l11_fx(regs_q[rr_q][clc_pkg::IDX_REVF]);
    assign rev_eff  = rev_raw >= 0 ? clc_pkg::REV_MAX : rev_raw; // [RQ16]
    // Die temperature stands in for a dead diode [RQ14]
    assign t_use    = ext_valid[rr_q] ? ext_temp[rr_q] : die_temp;
    assign dtemp    = 18'(t_use) + 18'(signed'(self_heat[rr_q]))
                      - clc_pkg::T_REF;
    // Signed ppm per degree, divided by 1e6 via scaled product [RQ17]
    assign ppm_prod = 64'(signed'(regs_q[rr_q][clc_pkg::IDX_TC]))
                      * 64'(dtemp) * 64'(clc_pkg::PPM_K);
    assign corr_raw = sat32(64'(clc_pkg::FX_ONE) + (ppm_prod >>> 20));
    assign corr     = corr_raw < clc_pkg::CORR_MIN ? clc_pkg::CORR_MIN
                    : corr_raw > clc_pkg::CORR_MAX ? clc_pkg::CORR_MAX
                    : corr_raw; // [RQ13]
    assign gc       = fx_mul(gain_eff, corr);
    // gc is never below 0.0025 mOhm, so the divide is safe
    assign i_quot   = (64'(signed'(sense_mv[rr_q])) <<< 16) / 64'(gc);
    assign coef_fx  = l11_fx(regs_q[rr_q][clc_pkg::IDX_DCOEF]);
    assign thr      = fx_mul(coef_fx, 32'(vout_target[rr_q]));

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rr_q       <= '0;
            iout_q     <= '0;
            oc_trip_q  <= '0;
            rev_trip_q <= '0;
            thr_q      <= '0;
            chk_en_q   <= '0;
        end else begin
            rr_q <= 32'(rr_q) == NUM_CH - 1 ? '0 : rr_q + 1'b1;
            iout_q[rr_q]     <= sat32(i_quot); // [RQ12]
            oc_trip_q[rr_q]  <= fx_mul(oc_eff, gc); // [RQ12]
            rev_trip_q[rr_q] <= fx_mul(rev_eff, gc); // [RQ12]
            thr_q[rr_q]      <= thr;
            chk_en_q[rr_q]   <= coef_fx <= clc_pkg::FX_ONE; // [RQ4]
        end
    end

    // ----------------------------------------------------------------
    // Discharge check
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] on_prev_q;
    logic [NUM_CH-1:0] hold_q;
    logic [NUM_CH-1:0] exceed;
    logic [NUM_CH-1:0] decayed;
    logic [NUM_CH-1:0] fail;
    logic [NUM_CH-1:0] hold_d;
    logic [NUM_CH-1:0] flag_d;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_dis
        assign exceed[g]  = chk_en_q[g]
                            && 32'(vout_meas[g]) > thr_q[g];
        assign decayed[g] = !chk_en_q[g]
                            || 32'(vout_meas[g]) < thr_q[g];
        assign fail[g]    = on_cmd[g] && !on_prev_q[g] && exceed[g];
        // Held until the output falls below threshold [RQ3]
        assign hold_d[g]  = on_cmd[g]
                            && (fail[g] || (hold_q[g] && !decayed[g]));
        // New failure wins over a clear in the same cycle [RQ2]
        assign flag_d[g]  = fail[g]
                            || (discharge_flag_q[g] && !clear_faults);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            on_prev_q            <= '0;
            hold_q               <= '0;
            chan_on_q            <= '0;
            discharge_flag_q     <= '0;
            alert_low_pin_o_q    <= 1'b0;
            alert_low_pin_oe_n_q <= 1'b1;
        end else begin
            on_prev_q            <= on_cmd;
            hold_q               <= hold_d;
            chan_on_q            <= on_cmd & ~hold_d; // [RQ3]
            discharge_flag_q     <= flag_d;
            alert_low_pin_o_q    <= 1'b0;
            alert_low_pin_oe_n_q <= ~|flag_d; // [RQ2]
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_fmt_read_value: assert property ( // [RQ1]
        @(posedge clk_sys) disable iff (!resetn)
        cmd_valid && !cmd_write && is_fmt && page_ok
        |=> rsp_ack_q && rsp_data_q == 16'h0013)
        else $error("format byte readback wrong");

    a_dac_upper_zero: assert property ( // [RQ10]
        @(posedge clk_sys) disable iff (!resetn)
        cmd_valid && !cmd_write && is_dac |=> rsp_data_q[15:10] == 6'h00)
        else $error("dac word upper bits not zero");

    a_dac_write_dropped: assert property ( // [RQ9]
        @(posedge clk_sys) disable iff (!resetn)
        cmd_valid && cmd_write && is_dac && !cfg_dac_mode[cmd_page][1]
        && soft_done == '0
        |=> rsp_valid_q && !rsp_ack_q
            && $stable(dac_reg_q))
        else $error("dac write taken in disallowed mode");

    a_hard_connect_pulse: assert property ( // [RQ6]
        @(posedge clk_sys) disable iff (!resetn)
        cfg_dac_mode[0] == 2'b10 && $past(cfg_dac_mode[0]) != 2'b10
        |-> ##1 dac_hard_q[0] ##1 !dac_hard_q[0])
        else $error("hard connect pulse missing");

    a_discharge_flag_set: assert property ( // [RQ2]
        @(posedge clk_sys) disable iff (!resetn)
        fail[0] |=> discharge_flag_q[0] && !alert_low_pin_oe_n_q
                    && !chan_on_q[0])
        else $error("discharge failure not flagged");

    a_hold_until_decay: assert property ( // [RQ3]
        @(posedge clk_sys) disable iff (!resetn)
        hold_q[0] && on_cmd[0] && !decayed[0] |=> !chan_on_q[0])
        else $error("channel on before output decayed");

    a_check_disabled: assert property ( // [RQ4]
        @(posedge clk_sys) disable iff (!resetn)
        !chk_en_q[0] && on_cmd[0] && !hold_q[0] |=> chan_on_q[0])
        else $error("disabled check still held channel");

    a_corr_in_range: assert property ( // [RQ13]
        @(posedge clk_sys) disable iff (!resetn)
        corr >= 32'sh0000_4000 && corr <= 32'sh0004_0000)
        else $error("thermal correction out of range");

    a_limit_clamps: assert property ( // [RQ15]
        @(posedge clk_sys) disable iff (!resetn)
        oc_eff >= 0 && rev_eff < 0 && gain_eff >= 32'sh0000_028F)
        else $error("internal limit clamp broken");

endmodule : clc_regs

// *** tb/channel_limit_calibration_regs_tb.sv ***
// Purpose: Self-checking bench for the limit and calibration registers
// Assumes: Four channels, commands one cycle apart at the least
// Notes:   Channel 0 analog inputs are exercised; channel 1 only for its self heating readback
`timescale 1ns/100ps
module channel_limit_calibration_regs_tb;
    localparam int N = 4;
    logic clk_sys = 1'b0, resetn = 1'b0, clear_faults = 1'b0;
    logic cmd_valid, cmd_write, rsp_valid_q, rsp_ack_q, hang;
    logic alert_low_pin_o_q, alert_low_pin_oe_n_q;
    logic [1:0]  cmd_page;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, rsp_data_q, die_temp = 16'h0190;
    logic [N-1:0] on_cmd = '0, rise_done = '0, soft_done = '0, ext_valid = '1;
    logic [N-1:0] chan_on_q, discharge_flag_q, dac_hard_q, dac_soft_q;
    logic [N-1:0][1:0]  cfg_dac_mode = '0;
    logic [N-1:0][9:0]  soft_code = {N{10'h155}}, dac_code_q;
    logic [N-1:0][15:0] vout_target = {N{16'h2000}}, vout_meas = '0;
    logic [N-1:0][15:0] ext_temp = {N{16'h0190}}, self_heat = 64'h0030_0000;
    logic [N-1:0][31:0] sense_mv = {N{32'h0001_0000}};
    logic [N-1:0][31:0] iout_q, oc_trip_q, rev_trip_q;
    int n_tests = 0, bad_count = 0;

    always #5 clk_sys = ~clk_sys;

    clc_regs #(.NUM_CH(N), .PW(2)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q),
        .rsp_ack_q(rsp_ack_q), .rsp_data_q(rsp_data_q), .on_cmd(on_cmd),
        .rise_done(rise_done), .vout_target(vout_target),
        .vout_meas(vout_meas), .clear_faults(clear_faults),
        .chan_on_q(chan_on_q), .discharge_flag_q(discharge_flag_q),
        .alert_low_pin_o_q(alert_low_pin_o_q),
        .alert_low_pin_oe_n_q(alert_low_pin_oe_n_q),
        .cfg_dac_mode(cfg_dac_mode), .soft_done(soft_done),
        .soft_code(soft_code), .dac_code_q(dac_code_q),
        .dac_hard_q(dac_hard_q), .dac_soft_q(dac_soft_q),
        .sense_mv(sense_mv), .ext_temp(ext_temp), .ext_valid(ext_valid),
        .self_heat(self_heat), .die_temp(die_temp), .iout_q(iout_q),
        .oc_trip_q(oc_trip_q), .rev_trip_q(rev_trip_q));

    clc_host_model host_u (
        .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q),
        .rsp_data_q(rsp_data_q), .hang(hang));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic w, input logic [1:0] pg,
                       input logic [7:0] c, input logic [15:0] wd,
                       input logic ea, input logic [15:0] ed);
        logic        ack;
        logic [15:0] d;
        host_u.xfer(w, pg, c, wd, ack, d);
        chk({31'h0, ack}, {31'h0, ea});
        chk({16'h0, d}, {16'h0, ed});
    endtask : cmd

    task automatic rd(input logic [1:0] pg, input logic [23:0] cv);
        cmd(1'b0, pg, cv[23:16], 16'h0000, 1'b1, cv[15:0]);
    endtask : rd

    task automatic wr(input logic [7:0] c, input logic [15:0] wd,
                      input logic ea);
        cmd(1'b1, 2'd0, c, wd, ea, 16'h0000);
    endtask : wr

    task automatic wait_on(input logic v);
        int n;
        for (n = 0; n < 20 && chan_on_q[0] !== v; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({31'h0, chan_on_q[0]}, {31'h0, v});
    endtask : wait_on

    task automatic t_reset();
        logic [23:0] t [15] = '{24'h38_BA00, 24'h46_D280, 24'h4A_CA80,
            24'h4B_B400, 24'h4F_EA08, 24'h51_E3C0, 24'h52_8000, 24'h53_CD80,
            24'hB9_8000, 24'hBA_8000, 24'hE9_C200, 24'hF6_0000,
            24'hF8_4000, 24'hF9_8000, 24'hE0_0000};
        for (int i = 0; i < 8; i++)
            rd(2'd0, t[i]);
        for (int i = 8; i < 15; i++)
            rd(2'd3, t[i]);
        rd(2'd1, 24'h20_0013);
        rd(2'd1, 24'hB8_0030);
        wr(8'h20, 16'h00FF, 1'b0);
        wr(8'h99, 16'h1234, 1'b0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_meas();
        repeat (8) @(posedge clk_sys);
        chk(iout_q[0], 32'h0001_0000);
        chk(oc_trip_q[0], 32'h000A_0000);
        chk(rev_trip_q[0], 32'hFFFF_0000);
        wr(8'h46, 16'hBC00, 1'b1);
        wr(8'h4B, 16'h0000, 1'b1);
        wr(8'hF6, 16'h7FFF, 1'b1);
        @(posedge clk_sys);
        ext_temp[0] <= 16'h7FF0;
        repeat (8) @(posedge clk_sys);
        rd(2'd0, 24'h46_BC00);
        rd(2'd0, 24'h4B_0000);
        chk(oc_trip_q[0], 32'h0000_0000);
        chk({31'h0, rev_trip_q[0][31]}, 32'h1);
        chk(iout_q[0], 32'h0000_4000);
        @(posedge clk_sys);
        ext_valid[0] <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(iout_q[0], 32'h0001_0000);
        wr(8'h38, 16'h0000, 1'b1);
        repeat (8) @(posedge clk_sys);
        rd(2'd0, 24'h38_0000);
        chk({31'h0, iout_q[0] > 32'h0050_0000}, 32'h1);
        $display("measurement test done");
    endtask : t_meas

    task automatic t_disch();
        @(posedge clk_sys);
        vout_meas[0] <= 16'h5000;
        on_cmd[0]    <= 1'b1;
        wait_on(1'b1);
        chk({31'h0, discharge_flag_q[0]}, 32'h0);
        wr(8'hE9, 16'hBA00, 1'b1);
        @(posedge clk_sys);
        on_cmd[0] <= 1'b0;
        wait_on(1'b0);
        repeat (8) @(posedge clk_sys);
        on_cmd[0] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({discharge_flag_q[0], alert_low_pin_oe_n_q, alert_low_pin_o_q},
            3'b100);
        chk({31'h0, chan_on_q[0]}, 32'h0);
        vout_meas[0] <= 16'h1000;
        wait_on(1'b1);
        @(posedge clk_sys);
        clear_faults <= 1'b1;
        @(posedge clk_sys);
        clear_faults <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({discharge_flag_q[0], alert_low_pin_oe_n_q}, 2'b01);
        $display("discharge test done");
    endtask : t_disch

    task automatic t_dac();
        @(posedge clk_sys);
        rise_done[0] <= 1'b1;
        wr(8'hE0, 16'h0155, 1'b0);
        @(posedge clk_sys);
        cfg_dac_mode[0] <= 2'b01;
        wr(8'hE0, 16'h0155, 1'b0);
        @(posedge clk_sys);
        cfg_dac_mode[0] <= 2'b10;
        @(posedge clk_sys);
        #1;
        chk({dac_hard_q[0], dac_soft_q[0]}, 2'b10);
        wr(8'hE0, 16'hFFFF, 1'b1);
        rd(2'd0, 24'hE0_03FF);
        chk({22'h0, dac_code_q[0]}, 32'h0000_03FF);
        @(posedge clk_sys);
        rise_done[0]    <= 1'b0;
        cfg_dac_mode[0] <= 2'b11;
        @(posedge clk_sys);
        #1;
        chk({dac_hard_q[0], dac_soft_q[0]}, 2'b01);
        wr(8'hE0, 16'h0001, 1'b0);
        @(posedge clk_sys);
        soft_done[0] <= 1'b1;
        @(posedge clk_sys);
        soft_done[0] <= 1'b0;
        rd(2'd0, 24'hE0_0155);
        $display("dac test done");
    endtask : t_dac

    task automatic tally_and_finish();
        if (hang !== 1'b0) bad_count++;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_meas();
        t_disch();
        t_dac();
        tally_and_finish();
    end
endmodule : channel_limit_calibration_regs_tb

// *** tb/clc_host_model.sv ***
// Purpose: Host side model issuing commands to the register set
// Assumes: One word per command, answer one cycle after the strobe
// Notes:   Idle data lines show the inverse of the last word
`timescale 1ns/100ps
module clc_host_model (
    // Clock
    input  wire logic        clk_sys,
    // Command port
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [1:0]       cmd_page,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic        rsp_valid_q,
    input  wire logic        rsp_ack_q,
    input  wire logic [15:0] rsp_data_q,
    // Status
    output logic             hang
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_page  = 2'h0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
        hang      = 1'b0;
    end

    task automatic xfer(input logic w, input logic [1:0] pg,
                        input logic [7:0] c, input logic [15:0] wd,
                        output logic ack, output logic [15:0] rd);
        int n;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_page  <= pg;
        cmd_code  <= c;
        cmd_wdata <= wd;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_code  <= ~c;
        cmd_wdata <= ~wd;
        #1;
        for (n = 0; n < 4 && rsp_valid_q !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        hang = hang | (n == 4);
        ack  = rsp_ack_q;
        rd   = rsp_data_q;
    endtask : xfer
endmodule : clc_host_model
